// ---- rtl/tsq_trigger_sequencer.sv ----
module tsq_trigger_sequencer #(
  parameter int DATA_W    = 32,
  parameter int MEM_DEPTH = 4096
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [11:0]       avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              sample_valid,
  input  wire logic [DATA_W-1:0] sample_data,
  input  wire logic [DATA_W-1:0] glitch_seen,
  input  wire logic [15:0]       other_claim,
  output logic                   store_strobe,
  output logic      [DATA_W-1:0] store_data,
  output logic                   trig_pulse,
  output logic                   mem_lock,
  output logic      [3:0]        seq_level,
  output logic      [15:0]       claim_granted
);

  logic [31:0]   ctrl_q;
  logic [15:0]   claim_q;
  logic [31:0]   cfg_q [tsq_pkg::CFG_LO:tsq_pkg::CFG_HI];
  logic          ack_q;
  logic          run_prev_q;
  logic [9:0]    widx;
  logic          access;
  logic [31:0]   rd_d;

  tsq_pkg::tsq_phase_type phase_q;
  logic [3:0]    level_q;
  logic [15:0]   occ_q;
  logic [31:0]   stab_q;
  logic          enter_q;
  logic          trig_seen_q;
  logic [31:0]   post_q;
  logic [DATA_W-1:0] prev_q;
  logic [31:0]   tmr_cnt_q [2];
  logic          tmr_run_q [2];

  localparam int NUM_PAT_W = tsq_pkg::NUM_PAT;
  logic [NUM_PAT_W-1:0] pat_hit;
  logic [1:0]    rng_in;
  logic [1:0]    edge_hit;
  logic [1:0]    tmr_lt;
  logic [1:0]    tmr_gt;
  logic [15:0]   res_a;
  logic [15:0]   res_b;
  logic [15:0]   avail;

  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    int i;
    r = old_v;
    for (i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic pair_op(input logic [2:0] op, input logic x, input logic y);
    logic r;
    unique case (op)
      tsq_pkg::OP_AND:  r = x & y;
      tsq_pkg::OP_NAND: r = ~(x & y);
      tsq_pkg::OP_OR:   r = x | y;
      tsq_pkg::OP_NOR:  r = ~(x | y);
      tsq_pkg::OP_XOR:  r = x ^ y;
      tsq_pkg::OP_XNOR: r = ~(x ^ y);
      default:          r = 1'b0;
    endcase
    return r;
  endfunction

  // Evaluates one expression over the fixed resource hierarchy.
  // Excluded operands drop out; an expression with nothing included never matches.
  function automatic logic tsq_eval(input logic [15:0] va, input logic [15:0] vb,
                                    input logic [15:0] av, input logic [31:0] sel,
                                    input logic [31:0] op);
    logic [1:0] s0;
    logic [1:0] s1;
    logic       u0;
    logic       u1;
    logic       x0;
    logic       x1;
    logic       pv;
    logic       acc_and;
    logic       acc_or;
    logic       any;
    logic [1:0] gv;
    logic [1:0] gi;
    logic       r;
    int g;
    int p;
    int k;
    gv = 2'h0;
    gi = 2'h0;
    for (g = 0; g < 2; g++) begin
      acc_and = 1'b1;
      acc_or  = 1'b0;
      any     = 1'b0;
      for (p = 0; p < 4; p++) begin
        k  = 8 * g + 2 * p;
        s0 = sel[2*k +: 2];
        s1 = sel[2*k+2 +: 2];
        u0 = av[k] & (s0 == tsq_pkg::SEL_ON || s0 == tsq_pkg::SEL_NEG);
        u1 = av[k+1] & (s1 == tsq_pkg::SEL_ON || s1 == tsq_pkg::SEL_NEG);
        x0 = (s0 == tsq_pkg::SEL_ON) ? va[k] : vb[k];
        x1 = (s1 == tsq_pkg::SEL_ON) ? va[k+1] : vb[k+1];
        pv = u0 & u1 ? pair_op(op[3*(4*g+p) +: 3], x0, x1) : (u0 ? x0 : x1);
        if (u0 | u1) begin
          acc_and = acc_and & pv;
          acc_or  = acc_or | pv;
          any     = 1'b1;
        end
      end
      gv[g] = op[tsq_pkg::OP_GPAIR_LSB + g] ? acc_or : acc_and;
      gi[g] = any;
    end
    if (gi == 2'h3) begin
      r = op[tsq_pkg::OP_GROUP] ? (gv[0] | gv[1]) : (gv[0] & gv[1]);
    end else if (gi[0]) begin
      r = gv[0];
    end else begin
      r = gi[1] & gv[1];
    end
    return r;
  endfunction

  // ---------------- Avalon slave ----------------
  assign access          = avs_read | avs_write;
  assign widx            = avs_address[11:2];
  // One wait cycle: request seen, answer on the next edge
  assign avs_waitrequest = access & ~ack_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
    end
  end

  always_comb begin
    rd_d = 32'h0000_0000;
    if (widx == tsq_pkg::OFF_CTRL[11:2]) begin
      rd_d = ctrl_q;
    end else if (widx == tsq_pkg::OFF_STATUS[11:2]) begin
      rd_d = {21'h000000, mem_lock, trig_seen_q, phase_q != tsq_pkg::PH_IDLE,
              4'h0, level_q};
    end else if (widx == tsq_pkg::OFF_CLAIM[11:2]) begin
      rd_d = {claim_granted, claim_q};
    end else if (int'(widx) >= tsq_pkg::CFG_LO && int'(widx) <= tsq_pkg::CFG_HI) begin
      rd_d = cfg_q[widx];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rd_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q  <= tsq_pkg::CTRL_RST;
      claim_q <= 16'h0000;
    end else if (avs_write && ack_q) begin
      if (widx == tsq_pkg::OFF_CTRL[11:2]) begin
        ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable);
      end
      if (widx == tsq_pkg::OFF_CLAIM[11:2]) begin
        claim_q <= 16'(be_merge({16'h0000, claim_q}, avs_writedata, avs_byteenable));
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = tsq_pkg::CFG_LO; i <= tsq_pkg::CFG_HI; i++) begin
        cfg_q[i] <= 32'h0000_0000;
      end
    end else if (avs_write && ack_q && int'(widx) >= tsq_pkg::CFG_LO
                 && int'(widx) <= tsq_pkg::CFG_HI) begin
      cfg_q[widx] <= be_merge(cfg_q[widx], avs_writedata, avs_byteenable);
    end
  end

  // a resource the other analyzer holds is never ours
  assign claim_granted = claim_q & ~other_claim;

  // ---------------- Resources ----------------
  localparam int PAT_VAL_W  = int'(tsq_pkg::OFF_PAT_VAL[11:2]);
  localparam int PAT_MASK_W = int'(tsq_pkg::OFF_PAT_MASK[11:2]);
  localparam int RLO_W      = int'(tsq_pkg::OFF_RANGE_LO[11:2]);
  localparam int RHI_W      = int'(tsq_pkg::OFF_RANGE_HI[11:2]);
  localparam int EMASK_W    = int'(tsq_pkg::OFF_EDGE_MASK[11:2]);
  localparam int ETYPE_W    = int'(tsq_pkg::OFF_EDGE_TYPE[11:2]);
  localparam int TPRE_W     = int'(tsq_pkg::OFF_TMR_PRE[11:2]);
  localparam int LVL_W      = int'(tsq_pkg::OFF_LEVEL[11:2]);
  localparam int LVL_BASE   = 0;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PAT_W; gp++) begin : g_pat
      // every masked label bit must match
      assign pat_hit[gp] = ((sample_data ^ cfg_q[PAT_VAL_W+gp][DATA_W-1:0])
                            & cfg_q[PAT_MASK_W+gp][DATA_W-1:0]) == '0;
    end
  endgenerate

  // two ranges, two edges, two timers, one of each per group
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pair
      logic [DATA_W-1:0] em;
      logic [DATA_W-1:0] rise;
      logic [DATA_W-1:0] fall;
      logic [2:0]        etype;
      logic [1:0]        act;
      assign em    = cfg_q[EMASK_W+gp][DATA_W-1:0];
      assign etype = cfg_q[ETYPE_W+gp][2:0];
      assign rise  = ~prev_q & sample_data & em;
      assign fall  = prev_q & ~sample_data & em;
      // inside test; outside is its negation
      assign rng_in[gp] = sample_data >= cfg_q[RLO_W+gp][DATA_W-1:0]
                          && sample_data <= cfg_q[RHI_W+gp][DATA_W-1:0];
      // any included channel, or none of them in none mode; glitches seen only in glitch mode
      always_comb begin
        unique case (etype)
          tsq_pkg::EDG_RISE:   edge_hit[gp] = |rise;
          tsq_pkg::EDG_FALL:   edge_hit[gp] = |fall;
          tsq_pkg::EDG_EITHER: edge_hit[gp] = |(rise | fall);
          tsq_pkg::EDG_GLITCH: edge_hit[gp] = |(glitch_seen & em);
          tsq_pkg::EDG_NONE:   edge_hit[gp] = ~|(rise | fall);
          default:             edge_hit[gp] = 1'b0;
        endcase
      end
      assign tmr_lt[gp] = tmr_cnt_q[gp] < cfg_q[TPRE_W+gp];
      assign tmr_gt[gp] = tmr_cnt_q[gp] > cfg_q[TPRE_W+gp];
      assign act = cfg_q[LVL_W + int'(level_q)*tsq_pkg::LVL_STRIDE + tsq_pkg::LW_CFG]
                   [tsq_pkg::CFG_TMR_LSB + 2*gp +: 2];
      // entry action applied once per level entry
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          tmr_cnt_q[gp] <= 32'h0000_0000;
          tmr_run_q[gp] <= 1'b0;
        end else if (enter_q) begin
          unique case (act)
            tsq_pkg::TMR_START: begin
              tmr_cnt_q[gp] <= 32'h0000_0000;
              tmr_run_q[gp] <= 1'b1;
            end
            tsq_pkg::TMR_STOP: begin
              tmr_cnt_q[gp] <= 32'h0000_0000;
              tmr_run_q[gp] <= 1'b0;
            end
            tsq_pkg::TMR_PAUSE: tmr_run_q[gp] <= 1'b0;
            tsq_pkg::TMR_CONT:  tmr_run_q[gp] <= 1'b1;
          endcase
        end else if (tmr_run_q[gp] && tmr_cnt_q[gp] != 32'hffff_ffff) begin
          tmr_cnt_q[gp] <= tmr_cnt_q[gp] + 32'h0000_0001;
        end
      end
      // (a,b) (c,range) (d,edge) (e,timer) in group one; f..j in two
      assign res_a[8*gp+0] = pat_hit[5*gp+0];
      assign res_a[8*gp+1] = pat_hit[5*gp+1];
      assign res_a[8*gp+2] = pat_hit[5*gp+2];
      assign res_a[8*gp+3] = rng_in[gp];
      assign res_a[8*gp+4] = pat_hit[5*gp+3];
      assign res_a[8*gp+5] = edge_hit[gp];
      assign res_a[8*gp+6] = pat_hit[5*gp+4];
      assign res_a[8*gp+7] = tmr_lt[gp];
      assign res_b[8*gp+6 -: 7] = ~res_a[8*gp+6 -: 7];
      assign res_b[8*gp+7] = tmr_gt[gp];
    end
  endgenerate

  // ---------------- Sequencer ----------------
  logic        timing;
  logic [3:0]  nlev;
  logic [3:0]  nlev_max;
  logic        is_last;
  logic [31:0] lcfg;
  logic [3:0]  else_tgt;
  logic        adv_hit;
  logic        else_hit;
  logic        store_hit;
  logic        adv_ok;
  logic        adv_met;
  logic        trig_lvl;
  logic        trig_now;
  logic        store_now;
  logic        lock_now;
  logic        arm;
  logic        active;
  logic [3:0]  next_level;
  logic [31:0] post_target;
  int          lb;

  assign timing   = ctrl_q[tsq_pkg::CTRL_TIMING];
  // level count clamped to the mode's limits
  assign nlev_max = timing ? 4'(tsq_pkg::MAX_LEV_TIME) : 4'(tsq_pkg::MAX_LEV_STATE);
  assign nlev     = ctrl_q[tsq_pkg::CTRL_NLEV_LSB +: 4] < 4'(tsq_pkg::MIN_LEVELS)
                    ? 4'(tsq_pkg::MIN_LEVELS)
                    : (ctrl_q[tsq_pkg::CTRL_NLEV_LSB +: 4] > nlev_max ? nlev_max
                       : ctrl_q[tsq_pkg::CTRL_NLEV_LSB +: 4]);
  assign is_last  = level_q == nlev - 4'h1;
  assign lb       = LVL_W + int'(level_q) * tsq_pkg::LVL_STRIDE + LVL_BASE;
  assign lcfg     = cfg_q[lb + tsq_pkg::LW_CFG];
  assign else_tgt = lcfg[tsq_pkg::CFG_ELSE_LSB +: 4];

  // edges only in timing; no timers at the first level
  assign avail = claim_granted & ~(timing ? 16'h0000 : tsq_pkg::EDGE_BITS)
                 & ~(level_q == 4'h0 ? tsq_pkg::TIMER_BITS : 16'h0000);

  // advance and else evaluated each sample
  assign adv_hit   = tsq_eval(res_a, res_b, avail, cfg_q[lb + tsq_pkg::LW_ADV_SEL],
                              cfg_q[lb + tsq_pkg::LW_ADV_OP]);
  assign else_hit  = tsq_eval(res_a, res_b, avail, cfg_q[lb + tsq_pkg::LW_ELSE_SEL],
                              cfg_q[lb + tsq_pkg::LW_ELSE_OP]);
  assign store_hit = tsq_eval(res_a, res_b, avail, cfg_q[lb + tsq_pkg::LW_STORE_SEL],
                              cfg_q[lb + tsq_pkg::LW_STORE_OP]);

  // trigger honoured only at the mode's allowed place
  assign trig_lvl = lcfg[tsq_pkg::CFG_TRIG] & (timing ? is_last : ~is_last);
  // count reached, or term stable long enough (zero acts as one)
  assign adv_ok = lcfg[tsq_pkg::CFG_DUR]
                  ? ({1'b0, stab_q} + 33'h1 >= {1'b0, cfg_q[lb + tsq_pkg::LW_DUR]})
                  : ({1'b0, occ_q} + 17'h1 >= {1'b0, lcfg[tsq_pkg::CFG_OCC_LSB +: 16]});
  // final level carries no advance unless it holds the trigger
  assign adv_met  = adv_hit & adv_ok & (~is_last | trig_lvl);
  assign active   = phase_q == tsq_pkg::PH_ARMED || phase_q == tsq_pkg::PH_POST;
  // trigger once, after count or duration
  assign trig_now = trig_lvl & adv_met & ~trig_seen_q & (phase_q == tsq_pkg::PH_ARMED);

  always_comb begin
    // advance goes to the next level only
    if (adv_met && !is_last) begin
      next_level = level_q + 4'h1;
    end else if (adv_met) begin
      next_level = level_q;
    // else wins only when advance is not met
    // any target below the level count
    end else if (else_hit && else_tgt < nlev) begin
      next_level = else_tgt;
    end else begin
      next_level = level_q;
    end
  end

  // store-none keeps advance hits unless disabled
  always_comb begin
    unique case (lcfg[tsq_pkg::CFG_STORE_LSB +: 2])
      tsq_pkg::STQ_ANY:  store_now = 1'b1;
      tsq_pkg::STQ_TERM: store_now = store_hit;
      tsq_pkg::STQ_NONE: store_now = (adv_met | trig_now) & ~ctrl_q[tsq_pkg::CTRL_BTNS];
      default:           store_now = 1'b0;
    endcase
    store_now = store_now | trig_now;
  end

  // stores after trigger set its place in memory
  always_comb begin
    unique case (ctrl_q[tsq_pkg::CTRL_POS_LSB +: 2])
      tsq_pkg::POS_BEGIN: post_target = 32'(MEM_DEPTH - 1);
      tsq_pkg::POS_MID:   post_target = 32'(MEM_DEPTH / 2);
      default:            post_target = 32'h0000_0000;
    endcase
  end
  assign lock_now = (trig_now && post_target == 32'h0000_0000)
                    || (phase_q == tsq_pkg::PH_POST && store_now
                        && post_q + 32'h1 >= post_target);
  assign arm      = ctrl_q[tsq_pkg::CTRL_RUN] & ~run_prev_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= ctrl_q[tsq_pkg::CTRL_RUN];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q     <= tsq_pkg::PH_IDLE;
      level_q     <= 4'h0;
      occ_q       <= 16'h0000;
      stab_q      <= 32'h0000_0000;
      enter_q     <= 1'b0;
      trig_seen_q <= 1'b0;
      post_q      <= 32'h0000_0000;
    end else begin
      enter_q <= 1'b0;
      if (arm) begin
        phase_q     <= tsq_pkg::PH_ARMED;
        level_q     <= 4'h0;
        occ_q       <= 16'h0000;
        stab_q      <= 32'h0000_0000;
        enter_q     <= 1'b1;
        trig_seen_q <= 1'b0;
        post_q      <= 32'h0000_0000;
      end else if (!ctrl_q[tsq_pkg::CTRL_RUN]) begin
        phase_q <= tsq_pkg::PH_IDLE;
      end else if (sample_valid && active) begin
        // memory locks once post-trigger stores complete
        if (lock_now) begin
          phase_q <= tsq_pkg::PH_DONE;
        end else if (trig_now) begin
          phase_q <= tsq_pkg::PH_POST;
        end
        if (trig_now) begin
          trig_seen_q <= 1'b1;
        end
        if (phase_q == tsq_pkg::PH_POST && store_now) begin
          post_q <= post_q + 32'h1;
        end
        // counters restart on every level change
        if (next_level != level_q) begin
          level_q <= next_level;
          occ_q   <= 16'h0000;
          stab_q  <= 32'h0000_0000;
          enter_q <= 1'b1;
        end else begin
          occ_q  <= adv_hit && occ_q != 16'hffff ? occ_q + 16'h1 : occ_q;
          stab_q <= adv_hit ? (stab_q != 32'hffff_ffff ? stab_q + 32'h1 : stab_q)
                            : 32'h0000_0000;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prev_q       <= '0;
      store_strobe <= 1'b0;
      store_data   <= '0;
      trig_pulse   <= 1'b0;
    end else begin
      store_strobe <= sample_valid & active & store_now;
      trig_pulse   <= sample_valid & active & trig_now;
      if (sample_valid) begin
        prev_q     <= sample_data;
        store_data <= sample_data;
      end
    end
  end

  assign mem_lock  = phase_q == tsq_pkg::PH_DONE;
  assign seq_level = level_q;

endmodule

// ---- rtl/tsq_pkg.sv ----
package tsq_pkg;
  // Register byte offsets (word aligned)
  localparam logic [11:0] OFF_CTRL      = 12'h000;
  localparam logic [11:0] OFF_STATUS    = 12'h004;
  localparam logic [11:0] OFF_CLAIM     = 12'h008;
  localparam logic [11:0] OFF_TMR_PRE   = 12'h010;
  localparam logic [11:0] OFF_EDGE_MASK = 12'h020;
  localparam logic [11:0] OFF_EDGE_TYPE = 12'h028;
  localparam logic [11:0] OFF_RANGE_LO  = 12'h030;
  localparam logic [11:0] OFF_RANGE_HI  = 12'h038;
  localparam logic [11:0] OFF_PAT_VAL   = 12'h040;
  localparam logic [11:0] OFF_PAT_MASK  = 12'h080;
  localparam logic [11:0] OFF_LEVEL     = 12'h100;
  localparam int          LVL_STRIDE    = 8;
  localparam int          CFG_LO        = 4;
  localparam int          CFG_HI        = 159;
  // Word positions inside one level block
  localparam int LW_ADV_SEL   = 0;
  localparam int LW_ADV_OP    = 1;
  localparam int LW_ELSE_SEL  = 2;
  localparam int LW_ELSE_OP   = 3;
  localparam int LW_STORE_SEL = 4;
  localparam int LW_STORE_OP  = 5;
  localparam int LW_CFG       = 6;
  localparam int LW_DUR       = 7;
  // Control register fields
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_TIMING   = 1;
  localparam int CTRL_BTNS     = 2;
  localparam int CTRL_POS_LSB  = 4;
  localparam int CTRL_NLEV_LSB = 8;
  localparam logic [31:0] CTRL_RST = 32'h0000_0200;
  // Level configuration word fields
  localparam int CFG_OCC_LSB   = 0;
  localparam int CFG_ELSE_LSB  = 16;
  localparam int CFG_STORE_LSB = 20;
  localparam int CFG_TRIG      = 22;
  localparam int CFG_DUR       = 23;
  localparam int CFG_TMR_LSB   = 24;
  // Expression operator word fields
  localparam int OP_GPAIR_LSB  = 24;
  localparam int OP_GROUP      = 26;
  // Sizes
  localparam int MIN_LEVELS    = 2;
  localparam int MAX_LEV_STATE = 12;
  localparam int MAX_LEV_TIME  = 10;
  localparam int NUM_PAT       = 10;
  localparam int NUM_RES       = 16;
  localparam logic [15:0] EDGE_BITS  = 16'h2020;
  localparam logic [15:0] TIMER_BITS = 16'h8080;
  // Resource selection codes
  localparam logic [1:0] SEL_OFF = 2'h0;
  localparam logic [1:0] SEL_ON  = 2'h1;
  localparam logic [1:0] SEL_NEG = 2'h2;
  // Pair operators
  localparam logic [2:0] OP_AND  = 3'h0;
  localparam logic [2:0] OP_NAND = 3'h1;
  localparam logic [2:0] OP_OR   = 3'h2;
  localparam logic [2:0] OP_NOR  = 3'h3;
  localparam logic [2:0] OP_XOR  = 3'h4;
  localparam logic [2:0] OP_XNOR = 3'h5;
  // Store qualifiers
  localparam logic [1:0] STQ_ANY  = 2'h0;
  localparam logic [1:0] STQ_NONE = 2'h1;
  localparam logic [1:0] STQ_TERM = 2'h2;
  // Timer entry actions
  localparam logic [1:0] TMR_CONT  = 2'h0;
  localparam logic [1:0] TMR_START = 2'h1;
  localparam logic [1:0] TMR_STOP  = 2'h2;
  localparam logic [1:0] TMR_PAUSE = 2'h3;
  // Transition kinds
  localparam logic [2:0] EDG_NONE   = 3'h0;
  localparam logic [2:0] EDG_RISE   = 3'h1;
  localparam logic [2:0] EDG_FALL   = 3'h2;
  localparam logic [2:0] EDG_EITHER = 3'h3;
  localparam logic [2:0] EDG_GLITCH = 3'h4;
  // Trigger position in memory
  localparam logic [1:0] POS_BEGIN = 2'h0;
  localparam logic [1:0] POS_MID   = 2'h1;
  typedef enum logic [1:0] {PH_IDLE, PH_ARMED, PH_POST, PH_DONE} tsq_phase_type;
endpackage

// ---- bench/tsq_sva.sv ----
module tsq_sva #(
  parameter int DATA_W = 32
) (
  input wire logic              sys_clk,
  input wire logic              resetn,
  input wire logic              sample_valid,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic [15:0]       other_claim,
  input wire logic              store_strobe,
  input wire logic [DATA_W-1:0] store_data,
  input wire logic              trig_pulse,
  input wire logic              mem_lock,
  input wire logic [3:0]        seq_level,
  input wire logic [15:0]       claim_granted
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence trig_hit;
    trig_pulse ##0 store_strobe;
  endsequence
  AST_TRIG_STORED: assert property (trig_pulse |-> trig_hit)
    else $error("trigger sample not stored");
  AST_STORE_CAUSE: assert property (store_strobe |-> $past(sample_valid))
    else $error("store without sample");
  AST_STORE_DATA: assert property (store_strobe |-> store_data == $past(sample_data))
    else $error("stored data wrong");
  AST_CLAIM_ONE: assert property ((claim_granted & other_claim) == 16'h0)
    else $error("resource granted twice");
  AST_LEVEL_MAX: assert property (seq_level < 4'hc)
    else $error("level out of range");
  AST_TRIG_NEXT: assert property (trig_pulse |->
    seq_level == $past(seq_level) + 4'h1 || $stable(seq_level)) else $error("trigger not next");
  AST_LEVEL_CAUSE: assert property ((seq_level != $past(seq_level) && seq_level != 4'h0)
    |-> $past(sample_valid)) else $error("level moved without sample");
  AST_LOCK_QUIET: assert property (mem_lock && $past(mem_lock) |-> !store_strobe)
    else $error("store while locked");
endmodule

bind tsq_trigger_sequencer tsq_sva #(.DATA_W(DATA_W)) chk_u (.sys_clk(sys_clk), .resetn(resetn),
  .sample_valid(sample_valid), .sample_data(sample_data), .other_claim(other_claim),
  .store_strobe(store_strobe), .store_data(store_data), .trig_pulse(trig_pulse),
  .mem_lock(mem_lock), .seq_level(seq_level), .claim_granted(claim_granted));

// ---- bench/tsq_probe.sv ----
module tsq_probe (
  input  wire logic        sys_clk,
  input  wire logic        send,
  input  wire logic [31:0] word,
  output logic             sample_valid,
  output logic [31:0]      sample_data,
  output logic [31:0]      glitch_seen
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle data shows the inverse word so a stale value never passes for a fresh sample
  always @(posedge sys_clk) begin
    sample_valid <= send;
    sample_data  <= send ? word : ~word;
    glitch_seen  <= '0;
  end
endmodule

// ---- bench/tsq_trigger_sequencer_tb.sv ----
module tsq_trigger_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, resetn, avs_read, avs_write, send, avs_waitrequest;
  logic        sample_valid, store_strobe, trig_pulse, mem_lock;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, word, rd, store_data, sample_data, glitch_seen;
  logic [3:0]  seq_level;
  logic [15:0] other_claim, claim_granted;
  int          err_total, tests_run, cyc;
  logic [11:0] wa [11] = '{12'h040, 12'h080, 12'h044, 12'h084, 12'h048, 12'h088,
                           12'h100, 12'h118, 12'h120, 12'h128, 12'h138};
  logic [31:0] wd [11] = '{32'h55, 32'hff, 32'haa, 32'hff, 32'h33, 32'hff,
                           32'h1, 32'h2, 32'h4, 32'h10, 32'h0050_0001};
  logic [7:0]  sv [8] = '{8'h55, 8'h55, 8'h11, 8'h33, 8'h55, 8'h55, 8'haa, 8'h55};
  logic [7:0]  ev [8] = '{8'h80, 8'h81, 8'h01, 8'h00, 8'h80, 8'h81, 8'he2, 8'h22};
  tsq_trigger_sequencer #(.MEM_DEPTH(16)) dut_u (.sys_clk(sys_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_valid(sample_valid),
    .sample_data(sample_data), .glitch_seen(glitch_seen), .other_claim(other_claim),
    .store_strobe(store_strobe), .store_data(store_data), .trig_pulse(trig_pulse),
    .mem_lock(mem_lock), .seq_level(seq_level), .claim_granted(claim_granted));
  tsq_probe probe_u (.sys_clk(sys_clk), .send(send), .word(word),
    .sample_valid(sample_valid), .sample_data(sample_data), .glitch_seen(glitch_seen));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic smp(input logic [7:0] v);
    @(posedge sys_clk);
    send <= 1'b1;
    word <= {24'h0, v};
    @(posedge sys_clk);
    send <= 1'b0;
    @(posedge sys_clk);
    #1;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    resetn = 1'b0;
    {avs_read, avs_write, avs_address, avs_writedata, send, word} = '0;
    other_claim = 16'h0100;
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    bus(1'b0, 12'h000, '0);
    chk("ctrl", tsq_pkg::CTRL_RST, rd);
    bus(1'b0, 12'hffc, '0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 12'h008, 32'h0000_0107);
    bus(1'b0, 12'h008, '0);
    chk("claim", 32'h0007_0107, rd);
    chk("granted", 32'h7, {16'h0, claim_granted});
    for (int i = 0; i < 11; i++) bus(1'b1, wa[i], wd[i]);
    // Three levels, state mode, trigger at end of memory
    bus(1'b1, 12'h000, 32'h0000_0321);
    for (int i = 0; i < 8; i++) begin
      smp(sv[i]);
      chk("walk", {24'h0, ev[i]},
        {24'h0, store_strobe, trig_pulse, mem_lock, 1'b0, seq_level});
      if (i == 6) chk("trig data", 32'haa, store_data);
    end
    bus(1'b0, 12'h004, '0);
    chk("status", 32'h0000_0702, rd);
    summarize();
  end
endmodule
